// ===== dv/bit_toggle_branch_call_clear_exec_tb.sv
// self-checking bench for the execution unit
`timescale 1ns/1ps
module bit_toggle_branch_call_clear_exec_tb;
   reg         clk_i = 1'b0;
   reg         rst_i = 1'b1;
   reg         wb_cyc_i = 1'b0;
   reg         wb_stb_i = 1'b0;
   reg         wb_we_i = 1'b0;
   reg  [7:0]  wb_adr_i = 8'h00;
   reg  [3:0]  wb_sel_i = 4'h0;
   reg  [31:0] wb_dat_i = 32'h00000000;
   wire [31:0] wb_dat_o;
   wire        wb_ack_o;
   wire        busy_o;
   reg  [3:0]  idx = 4'h0;
   wire [15:0] word;
   reg  [31:0] rd;
   integer     mismatches = 0;
   integer     total_checks = 0;
   integer     busy_cycles = 0;
   integer     d0;
   integer     d1;

   exec_core uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .busy_o(busy_o));
   prog_rom rom (.idx_i(idx), .word_o(word));

   always #25 clk_i = ~clk_i;
   always @(posedge clk_i) if (busy_o === 1'b1) busy_cycles <= busy_cycles + 1;
   ////////////////////////////////////////////////////////////////////////////
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", total_checks, mismatches);
         if (mismatches == 0 && total_checks > 0) begin
            $display("Simulation passed");
         end else begin
            $display("Simulation failed");
         end
         $finish;
      end
   endtask
   task check(input [63:0] name, input [31:0] exp, input [31:0] got);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("ERROR %0s expected %h seen %h", name, exp, got);
         end
      end
   endtask
   // request launched after an edge, held until ack is sampled
   task xfer(input we, input [7:0] adr, input [31:0] dat);
      integer n;
      begin
         @(posedge clk_i);
         wb_cyc_i <= 1'b1;
         wb_stb_i <= 1'b1;
         wb_we_i  <= we;
         wb_adr_i <= adr;
         wb_sel_i <= 4'hF;
         wb_dat_i <= dat;
         n = 0;
         @(posedge clk_i);
         while (wb_ack_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n = n + 1;
         end
         if (n == 20) begin
            check("ack", 32'h1, 32'h0);
            print_verdict;
         end
         rd = wb_dat_o;
         wb_cyc_i <= 1'b0;
         wb_stb_i <= 1'b0;
      end
   endtask
   task wr(input [7:0] adr, input [31:0] dat);
      xfer(1'b1, adr, dat);
   endtask
   task rdc(input [7:0] adr, input [31:0] exp, input [63:0] name);
      begin
         xfer(1'b0, adr, 32'h00000000);
         check(name, exp, rd);
      end
   endtask
   task exec(input [3:0] i);
      begin
         idx = i;
         #1;
         wr(8'h00, {16'h0000, word});
      end
   endtask
   task wait_idle;
      integer n;
      begin
         n = 0;
         rd = 32'h00000003;
         while (rd[1:0] !== 2'b00 && n < 40) begin
            xfer(1'b0, 8'h24, 32'h00000000);
            n = n + 1;
         end
         if (n == 40) begin
            check("idle", 32'h0, rd);
            print_verdict;
         end
      end
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      rdc(8'h04, 32'h0, "pc");
      rdc(8'h14, 32'h0, "shadow");
      rdc(8'h18, 32'h0, "tos");
      rdc(8'h3C, 32'h0, "unmapped");
      $display("test reset done");
      wr(8'h10, 32'h2);
      wr(8'h08, 32'h8);
      wr(8'h1C, 32'h234);
      wr(8'h20, 32'h75);
      exec(4'h0);
      wait_idle;
      rdc(8'h20, 32'h65, "bitinv");
      rdc(8'h08, 32'h8, "flags");
      wr(8'h1C, 32'hF90);
      wr(8'h20, 32'h01);
      exec(4'h1);
      wait_idle;
      rdc(8'h20, 32'h00, "accbank");
      $display("test bit invert done");
      wr(8'h1C, 32'h234);
      exec(4'h2);
      wait_idle;
      rdc(8'h20, 32'h00, "clear");
      rdc(8'h08, 32'hC, "flags");
      rdc(8'h04, 32'h6, "pc");
      $display("test clear done");
      wr(8'h08, 32'h0);
      d0 = busy_cycles;
      exec(4'h4);
      wait_idle;
      d0 = busy_cycles - d0;
      rdc(8'h04, 32'h8, "pc");
      wr(8'h04, 32'h100);
      wr(8'h08, 32'h8);
      d1 = busy_cycles;
      // second word lands in the slot during the taken branch
      exec(4'h3);
      exec(4'h8);
      wait_idle;
      d1 = busy_cycles - d1;
      check("cycles", 32'd4, d1 - d0);
      rdc(8'h04, 32'hFE, "pc");
      rdc(8'h24, 32'h100, "discard");
      wr(8'h24, 32'h0);
      rdc(8'h24, 32'h0, "discclr");
      wr(8'h04, 32'h200);
      wr(8'h08, 32'h4);
      exec(4'h4);
      wait_idle;
      rdc(8'h04, 32'h300, "pc");
      rdc(8'h08, 32'h4, "flags");
      exec(4'h3);
      wait_idle;
      rdc(8'h04, 32'h302, "pc");
      $display("test branch done");
      wr(8'h04, 32'h40);
      wr(8'h0C, 32'h5A);
      wr(8'h10, 32'h3);
      wr(8'h08, 32'h1C);
      exec(4'h5);
      exec(4'h6);
      wait_idle;
      rdc(8'h04, 32'h24668, "pc");
      rdc(8'h18, 32'h44, "tos");
      rdc(8'h14, 32'h31C5A, "shadow");
      wr(8'h0C, 32'h11);
      exec(4'h7);
      exec(4'h6);
      wait_idle;
      rdc(8'h18, 32'h2466C, "tos");
      rdc(8'h14, 32'h31C5A, "shadow");
      $display("test call done");
      print_verdict;
   end
endmodule // bit_toggle_branch_call_clear_exec_tb

// ===== dv/exec_core_sva.sv
// bus and engine assertions for the execution unit
`timescale 1ns/1ps
module exec_core_sva (
   input wire        clk_i,
   input wire        rst_i,
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire        wb_we_i,
   input wire [7:0]  wb_adr_i,
   input wire [3:0]  wb_sel_i,
   input wire [31:0] wb_dat_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   input wire        busy_o
);
   wire      take = wb_cyc_i && wb_stb_i && !wb_ack_o;
   reg [6:0] busy_run;
   // saturate so a hung engine keeps failing
   always @(posedge clk_i) begin
      if (rst_i || !busy_o) busy_run <= 7'h00;
      else if (busy_run != 7'h7F) busy_run <= busy_run + 7'h01;
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   ack_latency_a: assert property (take |=> wb_ack_o)
      else $error("ack late");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");
   ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
      else $error("read data outside ack");
   reset_quiet_a: assert property (@(posedge clk_i) disable iff (1'b0)
      rst_i |=> !wb_ack_o && !busy_o) else $error("reset not quiet");
   unmapped_zero_a: assert property (take && !wb_we_i
      && wb_adr_i[7:2] > 6'h09 |=> wb_dat_o == 32'h00000000)
      else $error("unmapped read not zero");
   busy_start_a: assert property (take && wb_we_i && wb_sel_i[0]
      && wb_adr_i[7:2] == 6'h00 |-> ##[1:2] busy_o)
      else $error("engine not started");
   busy_bound_a: assert property (busy_run < 7'h28)
      else $error("engine busy too long");
   cover property (take && wb_we_i);
   cover property (take && !wb_we_i);
   cover property ($fell(busy_o));
endmodule // exec_core_sva
bind exec_core exec_core_sva chk (.clk_i(clk_i), .rst_i(rst_i),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .busy_o(busy_o));

// ===== dv/prog_rom.sv
// program memory model holding the instruction words
`timescale 1ns/1ps
module prog_rom (
   // fetch port
   input  wire [3:0]  idx_i,
   output reg  [15:0] word_o
);
   always @* begin
      case (idx_i)
         4'h0: word_o = 16'h7934;
         4'h1: word_o = 16'h7090;
         4'h2: word_o = 16'h6B34;
         4'h3: word_o = 16'hE4FE;
         4'h4: word_o = 16'hE07F;
         4'h5: word_o = 16'hED34;
         4'h6: word_o = 16'hF123;
         4'h7: word_o = 16'hEC34;
         default: word_o = 16'h0000;
      endcase
   end
endmodule // prog_rom

// ===== rtl/exec_core.v
// execution unit: bit invert, branch on overflow/zero, call, clear file
//
// Behaviour
// - bit invert flips bit b of f, flags kept
// - decode 0111 bbb a ffffffff as bit invert
// - a=0 access bank, a=1 uses bank register
// - overflow branch: pc plus 2 plus 2n
// - decode upper byte 1110 0100 as overflow branch
// - zero branch: pc plus 2 plus 2n
// - decode upper byte 1110 0000 as zero branch
// - branch one cycle, taken adds idle cycle
// - call pushes pc plus 4 to stack
// - fast bit copies w, flags, bank to shadows
// - call loads 20-bit target into pc[20:1]
// - call: two words, push, write pc, idle
// - clear file writes zero and sets zero flag
//
// Implementation choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`include "exec_core_map.vh"

module exec_core #(
   parameter DMEM_AW = 12
) (
   // clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [7:0]  wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // engine state
   output reg         busy_o
);

   localparam [4:0] ST_IDLE = 5'b00001;
   localparam [4:0] ST_Q1   = 5'b00010;
   localparam [4:0] ST_Q2   = 5'b00100;
   localparam [4:0] ST_Q3   = 5'b01000;
   localparam [4:0] ST_Q4   = 5'b10000;

   reg  [4:0]               state;
   reg                      second;
   reg  [15:0]              ir;
   reg  [15:0]              fetch_word;
   reg                      fetch_full;
   reg  [7:0]               opnd;
   reg  [7:0]               result;
   reg  [7:0]               k_lo;
   reg  [20:0]              pc;
   reg  [`FLAGS_W-1:0]      flags;
   reg  [7:0]               work;
   reg  [3:0]               bank_select_register;
   reg  [7:0]               working_shadow;
   reg  [`FLAGS_W-1:0]      flags_shadow;
   reg  [3:0]               bank_select_shadow;
   reg  [20:0]              top_of_return_stack;
   reg  [DMEM_AW-1:0]       daddr;
   reg  [7:0]               discards;
   reg  [7:0]               dmem [0:(1<<DMEM_AW)-1];

   wire                     bus_req;
   wire                     bus_wr;
   wire [5:0]               bus_idx;
   wire                     idle;
   wire                     bit_invert_op;
   wire                     branch_if_overflow;
   wire                     branch_if_zero_flag;
   wire                     call_op;
   wire                     clear_file_register;
   wire                     br_taken;
   wire [11:0]              file_addr;
   wire [20:0]              br_target;
   wire [7:0]               inv_byte;
   wire                     drop_now;

   ////////////////////////////////////////////////////////////////////////
   // decode

   assign bit_invert_op       = (ir[15:12] == `OP_BITINV);
   assign branch_if_overflow  = (ir[15:8] == `OP_BR_OV);
   assign branch_if_zero_flag = (ir[15:8] == `OP_BR_Z);
   assign call_op             = (ir[15:9] == `OP_CALL);
   assign clear_file_register = (ir[15:9] == `OP_CLEAR_FILE_REGISTER);

   // access bank: low half from bank 0, high half from the top bank
   assign file_addr = ir[8] ? {bank_select_register, ir[7:0]} :
                      (ir[7] ? {`ACC_HI_BANK, ir[7:0]} :
                               {`ACC_LO_BANK, ir[7:0]});

   // one mux per bit: only the selected bit is flipped
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : inv_bit
         localparam [2:0] BIT_SEL = g;
         assign inv_byte[g] = (ir[11:9] == BIT_SEL) ? ~opnd[g] : opnd[g];
      end
   endgenerate

   assign br_taken  = (branch_if_overflow & flags[`FLAG_OV]) |
                      (branch_if_zero_flag & flags[`FLAG_Z]);

   // sign-extended 2n added to pc plus 2
   assign br_target = pc + 21'h000002 +
                      {{12{ir[7]}}, ir[7:0], 1'b0};

   ////////////////////////////////////////////////////////////////////////
   // bus side

   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
   assign bus_idx = wb_adr_i[7:2];
   // architectural registers are only writable while the engine rests
   assign idle    = (state == ST_IDLE);
   // a word dropped in this cycle; it must survive a same-cycle clear
   assign drop_now = (state == ST_Q1) & second & fetch_full;

   always @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= 32'h00000000;
         if (bus_req && !wb_we_i) begin
            case (bus_idx)
               `REG_INSTR: wb_dat_o <= {16'h0000, fetch_word};
               `REG_PC:    wb_dat_o <= {11'h000, pc};
               `REG_FLAGS: wb_dat_o <= {27'h0000000, flags};
               `REG_WORK:  wb_dat_o <= {24'h000000, work};
               `REG_BANK:  wb_dat_o <= {28'h0000000, bank_select_register};
               `REG_SHADOW: begin
                  wb_dat_o <= {12'h000, bank_select_shadow,
                               3'h0, flags_shadow, working_shadow};
               end
               `REG_TOS:   wb_dat_o <= {11'h000, top_of_return_stack};
               `REG_DADDR: wb_dat_o <= {{(32-DMEM_AW){1'b0}}, daddr};
               `REG_DDATA: wb_dat_o <= {24'h000000, dmem[daddr]};
               `REG_STAT: begin
                  wb_dat_o <= {16'h0000, discards, 6'h00,
                               fetch_full, ~idle};
               end
               default:    wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // phase engine and architectural state

   always @(posedge clk_i) begin
      if (rst_i) begin
         state                <= ST_IDLE;
         second               <= 1'b0;
         ir                   <= 16'h0000;
         fetch_word           <= 16'h0000;
         fetch_full           <= 1'b0;
         opnd                 <= 8'h00;
         result               <= 8'h00;
         k_lo                 <= 8'h00;
         pc                   <= `PC_RST;
         flags                <= `FLAGS_RST;
         work                 <= `WORK_RST;
         bank_select_register <= `BANK_RST;
         working_shadow       <= 8'h00;
         flags_shadow         <= `FLAGS_RST;
         bank_select_shadow   <= 4'h0;
         top_of_return_stack  <= 21'h000000;
         daddr                <= {DMEM_AW{1'b0}};
         discards             <= 8'h00;
         busy_o               <= 1'b0;
      end else begin
         busy_o <= ~idle | fetch_full;
         case (state)
            ST_IDLE: begin
               if (fetch_full) begin
                  ir         <= fetch_word;
                  fetch_full <= 1'b0;
                  second     <= 1'b0;
                  state      <= ST_Q1;
               end
            end
            ST_Q1: begin
               // idle cycle drops whatever was fetched behind us
               if (second && fetch_full) begin
                  fetch_full <= 1'b0;
                  discards   <= discards + 8'h01;
               end
               state <= ST_Q2;
            end
            ST_Q2: begin
               if (!second) begin
                  opnd <= dmem[file_addr];
                  k_lo <= ir[7:0];
               end
               state <= ST_Q3;
            end
            ST_Q3: begin
               if (!second) begin
                  if (clear_file_register)
                     result <= 8'h00;
                  else
                     result <= inv_byte;
                  if (call_op) begin
                     top_of_return_stack <= pc + 21'h000004;
                     if (ir[8]) begin
                        working_shadow     <= work;
                        flags_shadow       <= flags;
                        bank_select_shadow <= bank_select_register;
                     end
                  end
               end
               state <= ST_Q4;
            end
            ST_Q4: begin
               if (second) begin
                  second <= 1'b0;
                  state  <= ST_IDLE;
               end else if (call_op) begin
                  // second word must arrive before the call completes
                  if (fetch_full) begin
                     pc <= {fetch_word[11:0], k_lo, 1'b0};
                     fetch_full <= 1'b0;
                     second     <= 1'b1;
                     state      <= ST_Q1;
                  end
               end else if (br_taken) begin
                  pc     <= br_target;
                  second <= 1'b1;
                  state  <= ST_Q1;
               end else begin
                  if (bit_invert_op || clear_file_register)
                     dmem[file_addr] <= result;
                  if (clear_file_register)
                     flags[`FLAG_Z] <= 1'b1;
                  pc    <= pc + 21'h000002;
                  state <= ST_IDLE;
               end
            end
            default: begin
               state  <= ST_IDLE;
               second <= 1'b0;
            end
         endcase

         // bus writes come last so a new word beats a same-cycle consume
         if (bus_wr) begin
            case (bus_idx)
               `REG_INSTR: begin
                  fetch_word <= wb_dat_i[15:0];
                  fetch_full <= 1'b1;
               end
               `REG_PC: begin
                  if (idle)
                     pc <= {wb_dat_i[20:1], 1'b0};
               end
               `REG_FLAGS: begin
                  if (idle)
                     flags <= wb_dat_i[`FLAGS_W-1:0];
               end
               `REG_WORK: begin
                  if (idle)
                     work <= wb_dat_i[7:0];
               end
               `REG_BANK: begin
                  if (idle)
                     bank_select_register <= wb_dat_i[3:0];
               end
               `REG_DADDR: daddr <= wb_dat_i[DMEM_AW-1:0];
               `REG_DDATA: begin
                  if (idle)
                     dmem[daddr] <= wb_dat_i[7:0];
               end
               `REG_STAT: discards <= {7'h00, drop_now};
               default: begin
                  discards <= discards;
               end
            endcase
         end
      end
   end

endmodule // exec_core

// ===== rtl/exec_core_map.vh
// register offsets, field positions and reset values of the execution block
`ifndef EXEC_CORE_MAP_VH
`define EXEC_CORE_MAP_VH

// word index of each register (byte address = 4 * index)
`define REG_INSTR       6'h00
`define REG_PC          6'h01
`define REG_FLAGS       6'h02
`define REG_WORK        6'h03
`define REG_BANK        6'h04
`define REG_SHADOW      6'h05
`define REG_TOS         6'h06
`define REG_DADDR       6'h07
`define REG_DDATA       6'h08
`define REG_STAT        6'h09

// flag positions in the status byte
`define FLAG_Z          2
`define FLAG_OV         3
`define FLAGS_W         5

// shadow register field positions
`define SHD_WORK_LSB    0
`define SHD_FLAGS_LSB   8
`define SHD_BANK_LSB    16

// engine status register fields
`define STAT_BUSY       0
`define STAT_FULL       1
`define STAT_DISC_LSB   8

// instruction patterns
`define OP_BITINV       4'h7
`define OP_BR_OV        8'hE4
`define OP_BR_Z         8'hE0
`define OP_CALL         7'h76
`define OP_CLEAR_FILE_REGISTER         7'h35

// banks used above and below the access bank split point
`define ACC_HI_BANK     4'hF
`define ACC_LO_BANK     4'h0

// reset values
`define PC_RST          21'h000000
`define FLAGS_RST       5'h00
`define WORK_RST        8'h00
`define BANK_RST        4'h0

`endif
